// ### design/vfd_pkg.sv
// constants, field layout and state encoding for the fetch/dispatch core
// assumes one core clock, program memory answering 256-bit fetch packets
package vfd_pkg;
    localparam int          FETCH_W     = 256;
    localparam int          SLOTS       = 8;
    localparam int          INSN_W      = 32;
    localparam logic [31:0] FETCH_BYTES = 32'h0000_0020;
    localparam logic [31:0] RESET_PC    = 32'h0000_0000;
    localparam int          NUM_REGS    = 32;
    localparam int          CIRC_BITS   = 8;
    // instruction word fields
    localparam int F_CHAIN   = 0;
    localparam int F_SIDE    = 1;
    localparam int F_KIND_LO = 2;
    localparam int F_CIRC    = 4;
    localparam int F_STORE   = 5;
    localparam int F_SIZE_LO = 6;
    localparam int F_OP_LO   = 8;
    localparam int F_OFFL_LO = 8;
    localparam int F_XPATH   = 12;
    localparam int F_LONG    = 12;
    localparam int F_SRC1_LO = 13;
    localparam int F_SRC2_LO = 18;
    localparam int F_DST_LO  = 23;
    localparam int F_ZERO    = 28;
    localparam int F_CREG_LO = 29;
    // unit kinds, unit index is {side, kind}
    localparam logic [1:0] KIND_LOGIC = 2'h0;
    localparam logic [1:0] KIND_SHIFT = 2'h1;
    localparam logic [1:0] KIND_MULT  = 2'h2;
    localparam logic [1:0] KIND_DATA  = 2'h3;
    // operation codes for non-data units
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_ADD = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_AND = 4'h3;
    localparam logic [3:0] OP_OR  = 4'h4;
    localparam logic [3:0] OP_XOR = 4'h5;
    localparam logic [3:0] OP_SHL = 4'h6;
    localparam logic [3:0] OP_SHR = 4'h7;
    localparam logic [3:0] OP_MPY = 4'h8;
    // access sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    // long-offset form uses this register of the unit's own side as base
    localparam logic [3:0] LONG_BASE_REG = 4'he;
    typedef enum logic [1:0] {
        VFD_ST_REQ  = 2'b00,
        VFD_ST_WAIT = 2'b01,
        VFD_ST_DISP = 2'b11
    } vfd_state_t;
endpackage

// ### design/vfd_core.sv
// fetch, execute-packet formation, dispatch, register files and the eight units
// program memory answers a request with one 256-bit packet; data memory
// answers each load with dm_rvalid some cycles later, before the next load
`timescale 1ns/10ps
module vfd_core (
    input  wire logic         core_clk,    // core clock, 100 MHz
    input  wire logic         sys_rst,     // async reset, active high
    input  wire logic         core_run,    // allow fetching
    output logic              pm_req,      // fetch request, held until pm_valid
    output logic [31:0]       pm_addr,     // fetch packet byte address
    input  wire logic         pm_valid,    // fetch packet present
    input  wire logic [255:0] pm_data,     // fetch packet, slot 0 in low bits
    output logic [1:0]        dm_req,      // data access strobe per data unit
    output logic [1:0]        dm_we,       // 1 store, 0 load
    output logic [63:0]       dm_addr,     // byte address per data unit
    output logic [7:0]        dm_be,       // byte enables per data unit
    output logic [63:0]       dm_wdata,    // store data per data unit
    input  wire logic [1:0]   dm_rvalid,   // load data present
    input  wire logic [63:0]  dm_rdata,    // load word per data unit
    output logic [7:0]        unit_issue,  // units that took an instruction
    output logic              pkt_done,    // one execute packet dispatched
    output logic              pkt_fault    // packet refused and nullified
);
    vfd_pkg::vfd_state_t state_r;
    logic [255:0] fp_r;
    logic [2:0]   ptr_r;
    logic [31:0]  pc_r;
    logic [31:0]  rf [vfd_pkg::NUM_REGS];
    logic [31:0]  slot [vfd_pkg::SLOTS];
    logic [2:0]   last;
    logic [7:0]   in_pkt;
    logic [31:0]  u_ins [8];
    logic [7:0]   u_vld;
    logic         dup;
    logic [1:0]   xrd_cnt [2];
    logic [1:0]   xwr_cnt [2];
    logic [7:0]   illegal;
    logic         fault;
    logic         disp;
    logic [7:0]   u_go;
    logic [31:0]  res [8];
    logic [7:0]   wr_en;
    logic [4:0]   wr_dst [8];
    logic [1:0]   ld_pend_r;
    logic [4:0]   ld_dst_r [2];
    logic [1:0]   ld_size_r [2];
    logic [1:0]   ld_lane_r [2];
    logic [31:0]  ld_val [2];

    assign disp = (state_r == vfd_pkg::VFD_ST_DISP);

    genvar gs;
    generate
        for (gs = 0; gs < vfd_pkg::SLOTS; gs++) begin : g_slot
            assign slot[gs] = fp_r[gs*vfd_pkg::INSN_W +: vfd_pkg::INSN_W];
        end
    endgenerate

    // cleared chain bit ends it; slot 7 always ends it
    always_comb begin
        logic found;
        found = 1'b0;
        last  = 3'h7;
        for (int i = 0; i < vfd_pkg::SLOTS; i++) begin
            if (!found && (3'(i) >= ptr_r) && !slot[i][vfd_pkg::F_CHAIN]) begin
                last  = 3'(i);
                found = 1'b1;
            end
        end
    end

    // every slot of the packet routed to its unit at once
    always_comb begin
        logic [2:0] ui;
        ui  = 3'h0;
        dup = 1'b0;
        u_vld = 8'h00;
        for (int u = 0; u < 8; u++) begin
            u_ins[u] = 32'h0000_0000;
        end
        for (int i = 0; i < vfd_pkg::SLOTS; i++) begin
            in_pkt[i] = (3'(i) >= ptr_r) && (3'(i) <= last);
            ui = {slot[i][vfd_pkg::F_SIDE], slot[i][vfd_pkg::F_KIND_LO +: 2]};
            // padding is skipped but still owns its cycle
            if (in_pkt[i] && (slot[i] != 32'h0000_0000)) begin
                if (u_vld[ui]) begin
                    dup = 1'b1;
                end
                u_vld[ui] = 1'b1;
                u_ins[ui] = slot[i];
            end
        end
    end

    // count cross-path reads and writes per side
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            xrd_cnt[s] = 2'h0;
            xwr_cnt[s] = 2'h0;
            for (int k = 0; k < 3; k++) begin
                if (u_vld[s*4+k] && u_ins[s*4+k][vfd_pkg::F_XPATH]) begin
                    xrd_cnt[s] = (xrd_cnt[s] == 2'h2) ? 2'h2 : xrd_cnt[s] + 2'h1;
                end
                if (u_vld[s*4+k] && (u_ins[s*4+k][vfd_pkg::F_DST_LO+4] != 1'(s))) begin
                    xwr_cnt[s] = (xwr_cnt[s] == 2'h2) ? 2'h2 : xwr_cnt[s] + 2'h1;
                end
            end
        end
    end

    // a refused packet is nullified whole rather than partly issued
    assign fault = dup || (|illegal) || (xrd_cnt[0] > 2'h1) || (xrd_cnt[1] > 2'h1)
                   || (xwr_cnt[0] > 2'h1) || (xwr_cnt[1] > 2'h1);

    // four units per side, unit index {side, kind}
    genvar gu;
    generate
        for (gu = 0; gu < 8; gu++) begin : g_unit
            localparam logic       SIDE = 1'(gu / 4);
            localparam logic [1:0] KIND = 2'(gu % 4);
            logic [3:0]  op;
            logic [2:0]  creg;
            logic        cond_ok;
            logic [31:0] opa;
            logic [31:0] opb;
            assign op   = u_ins[gu][vfd_pkg::F_OP_LO +: 4];
            assign creg = u_ins[gu][vfd_pkg::F_CREG_LO +: 3];
            // zero creg means always; else test side-A register creg
            assign cond_ok = (creg == 3'h0) ? 1'b1 :
                             (u_ins[gu][vfd_pkg::F_ZERO] ? (rf[{2'h0, creg}] == 32'h0)
                                                         : (rf[{2'h0, creg}] != 32'h0));
            // own-side operands read freely in the issue cycle
            assign opa = rf[{SIDE, u_ins[gu][vfd_pkg::F_SRC1_LO +: 4]}];
            // second operand may come over the cross path
            assign opb = rf[{SIDE ^ u_ins[gu][vfd_pkg::F_XPATH],
                            u_ins[gu][vfd_pkg::F_SRC2_LO +: 4]}];
            // multiply only on multiply units, nothing else there
            always_comb begin
                res[gu]     = 32'h0000_0000;
                illegal[gu] = 1'b0;
                if (KIND == vfd_pkg::KIND_MULT) begin
                    res[gu]     = 32'(opa[15:0] * opb[15:0]);
                    illegal[gu] = u_vld[gu] && (op != vfd_pkg::OP_MPY)
                                  && (op != vfd_pkg::OP_NOP);
                end else if (KIND != vfd_pkg::KIND_DATA) begin
                    case (op)
                        vfd_pkg::OP_NOP: res[gu] = 32'h0000_0000;
                        vfd_pkg::OP_ADD: res[gu] = opa + opb;
                        vfd_pkg::OP_SUB: res[gu] = opa - opb;
                        vfd_pkg::OP_AND: res[gu] = opa & opb;
                        vfd_pkg::OP_OR:  res[gu] = opa | opb;
                        vfd_pkg::OP_XOR: res[gu] = opa ^ opb;
                        vfd_pkg::OP_SHL: res[gu] = opa << opb[4:0];
                        vfd_pkg::OP_SHR: res[gu] = opa >> opb[4:0];
                        default: illegal[gu] = u_vld[gu];
                    endcase
                    if ((KIND == vfd_pkg::KIND_LOGIC)
                        && ((op == vfd_pkg::OP_SHL) || (op == vfd_pkg::OP_SHR))) begin
                        illegal[gu] = u_vld[gu];
                    end
                end
            end
            assign u_go[gu]   = disp && u_vld[gu] && !fault && cond_ok;
            assign wr_en[gu]  = u_go[gu] && (KIND != vfd_pkg::KIND_DATA)
                                && (op != vfd_pkg::OP_NOP);
            assign wr_dst[gu] = u_ins[gu][vfd_pkg::F_DST_LO +: 5];
        end
    endgenerate

    // only the two data units drive the memory ports
    genvar gd;
    generate
        for (gd = 0; gd < 2; gd++) begin : g_data
            localparam int U = gd*4 + 3;
            logic [31:0] ins;
            logic        lng;
            logic [1:0]  size;
            logic [31:0] base;
            logic [31:0] off;
            logic [31:0] sum;
            logic [31:0] addr;
            logic [31:0] src;
            logic [31:0] word;
            assign ins  = u_ins[U];
            assign lng  = ins[vfd_pkg::F_LONG];
            assign size = ins[vfd_pkg::F_SIZE_LO +: 2];
            assign base = lng ? rf[{1'(gd), vfd_pkg::LONG_BASE_REG}]
                              : rf[{1'(gd), ins[vfd_pkg::F_SRC2_LO +: 4]}];
            // 15-bit or 5-bit offset scaled by access size
            assign off = lng ? (32'(ins[vfd_pkg::F_OFFL_LO +: 15]) << size)
                             : (32'(ins[vfd_pkg::F_SRC1_LO +: 5]) << size);
            assign sum = base + off;
            // circular mode wraps inside an aligned block
            assign addr = ins[vfd_pkg::F_CIRC]
                          ? {base[31:vfd_pkg::CIRC_BITS], sum[vfd_pkg::CIRC_BITS-1:0]}
                          : sum;
            // store source may sit in either register file
            assign src = rf[ins[vfd_pkg::F_DST_LO +: 5]];
            assign word = dm_rdata[gd*32 +: 32];
            // byte and half loads pick their lane, zero-extended
            always_comb begin
                case (ld_size_r[gd])
                    vfd_pkg::SZ_BYTE: ld_val[gd] = 32'(word[ld_lane_r[gd]*8 +: 8]);
                    vfd_pkg::SZ_HALF: ld_val[gd] = 32'(word[ld_lane_r[gd][1]*16 +: 16]);
                    default:          ld_val[gd] = word;
                endcase
            end
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    dm_req[gd]             <= 1'b0;
                    dm_we[gd]              <= 1'b0;
                    dm_addr[gd*32 +: 32]   <= 32'h0000_0000;
                    dm_be[gd*4 +: 4]       <= 4'h0;
                    dm_wdata[gd*32 +: 32]  <= 32'h0000_0000;
                    ld_pend_r[gd]          <= 1'b0;
                    ld_dst_r[gd]           <= 5'h00;
                    ld_size_r[gd]          <= 2'h0;
                    ld_lane_r[gd]          <= 2'h0;
                end else begin
                    dm_req[gd] <= u_go[U];
                    if (u_go[U]) begin
                        dm_we[gd]            <= ins[vfd_pkg::F_STORE];
                        dm_addr[gd*32 +: 32] <= addr;
                        case (size)
                            vfd_pkg::SZ_BYTE: begin
                                dm_be[gd*4 +: 4]      <= 4'h1 << addr[1:0];
                                dm_wdata[gd*32 +: 32] <= {4{src[7:0]}};
                            end
                            vfd_pkg::SZ_HALF: begin
                                dm_be[gd*4 +: 4]      <= 4'h3 << {addr[1], 1'b0};
                                dm_wdata[gd*32 +: 32] <= {2{src[15:0]}};
                            end
                            default: begin
                                dm_be[gd*4 +: 4]      <= 4'hf;
                                dm_wdata[gd*32 +: 32] <= src;
                            end
                        endcase
                        ld_dst_r[gd]  <= ins[vfd_pkg::F_DST_LO +: 5];
                        ld_size_r[gd] <= size;
                        ld_lane_r[gd] <= addr[1:0];
                    end
                    // a new load wins over the answer of the old one
                    if (u_go[U] && !ins[vfd_pkg::F_STORE]) begin
                        ld_pend_r[gd] <= 1'b1;
                    end else if (dm_rvalid[gd]) begin
                        ld_pend_r[gd] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // all unit results written back in one edge; units win over loads
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int r = 0; r < vfd_pkg::NUM_REGS; r++) begin
                rf[r] <= 32'h0000_0000;
            end
        end else begin
            for (int d = 0; d < 2; d++) begin
                if (dm_rvalid[d] && ld_pend_r[d]) begin
                    rf[ld_dst_r[d]] <= ld_val[d];
                end
            end
            for (int u = 0; u < 8; u++) begin
                if (wr_en[u]) begin
                    rf[wr_dst[u]] <= res[u];
                end
            end
        end
    end

    // fetch only after the last packet leaves
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= vfd_pkg::VFD_ST_REQ;
            pc_r    <= vfd_pkg::RESET_PC;
            pm_req  <= 1'b0;
            pm_addr <= vfd_pkg::RESET_PC;
            fp_r    <= 256'h0;
            ptr_r   <= 3'h0;
        end else begin
            case (state_r)
                vfd_pkg::VFD_ST_REQ: begin
                    if (core_run) begin
                        pm_req  <= 1'b1;
                        pm_addr <= pc_r;
                        state_r <= vfd_pkg::VFD_ST_WAIT;
                    end
                end
                vfd_pkg::VFD_ST_WAIT: begin
                    // whole 256-bit packet taken at once
                    if (pm_valid) begin
                        pm_req  <= 1'b0;
                        fp_r    <= pm_data;
                        ptr_r   <= 3'h0;
                        pc_r    <= pc_r + vfd_pkg::FETCH_BYTES;
                        state_r <= vfd_pkg::VFD_ST_DISP;
                    end
                end
                vfd_pkg::VFD_ST_DISP: begin
                    // one to eight packets walked, one per cycle
                    // slot 7 closes the packet, nothing carries over
                    if (last == 3'h7) begin
                        state_r <= vfd_pkg::VFD_ST_REQ;
                    end else begin
                        ptr_r <= last + 3'h1;
                    end
                end
                default: state_r <= vfd_pkg::VFD_ST_REQ;
            endcase
        end
    end

    // one packet per dispatch cycle, reported per cycle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            unit_issue <= 8'h00;
            pkt_done   <= 1'b0;
            pkt_fault  <= 1'b0;
        end else begin
            unit_issue <= (disp && !fault) ? u_vld : 8'h00;
            pkt_done   <= disp;
            pkt_fault  <= disp && fault;
        end
    end
endmodule

// ### dv/vfd_core_sva.sv
// port assertions for the fetch/dispatch core
// bound to vfd_core from the bench top file
`timescale 1ns/10ps
module vfd_core_sva (
    input wire logic        core_clk,   // clock
    input wire logic        sys_rst,    // async reset
    input wire logic        core_run,   // fetch enable
    input wire logic        pm_req,     // fetch request
    input wire logic [31:0] pm_addr,    // fetch address
    input wire logic        pm_valid,   // fetch answer
    input wire logic [1:0]  dm_req,     // data strobes
    input wire logic [1:0]  dm_we,      // store flags
    input wire logic [7:0]  dm_be,      // byte enables
    input wire logic [7:0]  unit_issue, // issued units
    input wire logic        pkt_done,   // packet sent
    input wire logic        pkt_fault   // packet nullified
);
    logic        seen_r;
    logic [31:0] last_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seen_r <= 1'b0;
            last_r <= 32'h0000_0000;
        end else if (pm_req && pm_valid) begin
            seen_r <= 1'b1;
            last_r <= pm_addr;
        end
    end
    property p_req_hold; pm_req && !pm_valid |=> pm_req && $stable(pm_addr); endproperty
    a_req_hold: assert property (p_req_hold) else $error("fetch request dropped early");
    property p_addr_step; $rose(pm_req) |-> pm_addr == (seen_r ? last_r + 32'h20 : 32'h0); endproperty
    a_addr_step: assert property (p_addr_step) else $error("fetch address wrong");
    property p_first_pkt; pm_req && pm_valid |=> !pm_req ##1 pkt_done; endproperty
    a_first_pkt: assert property (p_first_pkt) else $error("first packet late");
    property p_no_fetch; pkt_done |-> !pm_req; endproperty
    a_no_fetch: assert property (p_no_fetch) else $error("fetch during dispatch");
    property p_refetch; $fell(pkt_done) && core_run |=> pm_req; endproperty
    a_refetch: assert property (p_refetch) else $error("next fetch missing");
    property p_rate; pkt_done |-> $past(pkt_done) || $past(pm_req && pm_valid, 2); endproperty
    a_rate: assert property (p_rate) else $error("dispatch gap");
    property p_fault; pkt_fault |-> pkt_done && unit_issue == 8'h00 && dm_req == 2'h0; endproperty
    a_fault: assert property (p_fault) else $error("faulted packet not nullified");
    property p_issue; unit_issue != 8'h00 |-> pkt_done; endproperty
    a_issue: assert property (p_issue) else $error("issue without packet");
    property p_mem; dm_req != 2'h0 |-> dm_req == (dm_req & {unit_issue[7], unit_issue[3]}); endproperty
    a_mem: assert property (p_mem) else $error("memory access by non-data unit");
    property p_be; dm_req[0] && dm_we[0] |-> dm_be[3:0] inside {4'hf, 4'h3, 4'hc, 4'h1, 4'h2,
        4'h4, 4'h8}; endproperty
    a_be: assert property (p_be) else $error("store byte enables malformed");
    c_fault: cover property (pkt_fault);
    c_wide: cover property (unit_issue == 8'hff);
    c_store: cover property (dm_req[0] && dm_we[0]);
endmodule

// ### dv/vfd_pmem_model.sv
// program memory model holding a small image of fetch packets
// answers each request with one packet; slow adds three wait cycles
`timescale 1ns/10ps
module vfd_pmem_model (
    input  wire logic        core_clk, // clock
    input  wire logic        sys_rst,  // async reset
    input  wire logic        slow,     // delay answers
    input  wire logic        pm_req,   // fetch request
    input  wire logic [31:0] pm_addr,  // fetch address
    output logic             pm_valid, // answer strobe
    output logic [255:0]     pm_data   // fetch packet
);
    logic [255:0] rom [4];
    logic [1:0]   wait_r;
    initial begin
        rom[0] = '0;
        rom[1] = {32'h0000_00ae, 32'h0800_080b, 32'h0800_0607, 32'h0800_0103,
                  32'h0000_00ad, 32'h0000_0809, 32'h0000_0605, 32'h0000_0101};
        rom[2] = {32'h0, 32'h0200_602c, 32'h0200_40ac, 32'h020c_6100,
                  32'h0, 32'h0, 32'h0, 32'h0180_208c};
        rom[3] = {160'h0, 32'h0000_0108, 32'h020c_6100, 32'h020c_6101};
    end
    // whole packet per request; idle data toggles
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pm_valid <= 1'b0;
            wait_r   <= 2'h0;
            pm_data  <= '1;
        end else if (pm_req && !pm_valid && wait_r >= (slow ? 2'h3 : 2'h0)) begin
            pm_valid <= 1'b1;
            pm_data  <= (pm_addr[31:7] == 25'h0) ? rom[pm_addr[6:5]] : '0;
            wait_r   <= 2'h0;
        end else begin
            pm_valid <= 1'b0;
            pm_data  <= ~pm_data;
            wait_r   <= (pm_req && !pm_valid) ? wait_r + 2'h1 : 2'h0;
        end
    end
endmodule

// ### dv/vliw_fetch_dispatch_bench.sv
// self-checking bench: image from the memory model, loads answered here
// assumes load answers may come one cycle after the strobe
`timescale 1ns/10ps
module vliw_fetch_dispatch_bench;
    logic         core_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         core_run = 1'b1;
    logic         slow = 1'b0;
    logic         pm_req, pm_valid, pkt_done, pkt_fault;
    logic [31:0]  pm_addr;
    logic [255:0] pm_data;
    logic [1:0]   dm_req, dm_we;
    logic [1:0]   dm_rvalid = 2'h0;
    logic [63:0]  dm_addr, dm_wdata;
    logic [63:0]  dm_rdata = 64'h0;
    logic [7:0]   dm_be, unit_issue;
    logic [67:0]  st_q [$];
    int           n_mismatch = 0;
    int           check_count = 0;
    always #5 core_clk = ~core_clk;
    vfd_core i_vfd_core (.core_clk(core_clk), .sys_rst(sys_rst), .core_run(core_run),
        .pm_req(pm_req), .pm_addr(pm_addr), .pm_valid(pm_valid), .pm_data(pm_data),
        .dm_req(dm_req), .dm_we(dm_we), .dm_addr(dm_addr), .dm_be(dm_be),
        .dm_wdata(dm_wdata), .dm_rvalid(dm_rvalid), .dm_rdata(dm_rdata),
        .unit_issue(unit_issue), .pkt_done(pkt_done), .pkt_fault(pkt_fault));
    vfd_pmem_model i_vfd_pmem_model (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
        .pm_req(pm_req), .pm_addr(pm_addr), .pm_valid(pm_valid), .pm_data(pm_data));
    // load answers; data inverted each idle cycle, so stale values match on every second idle cycle
    always @(posedge core_clk) begin
        dm_rvalid <= dm_req & ~dm_we;
        dm_rdata  <= ((dm_req & ~dm_we) != 2'h0) ? 64'h0000_0009_0000_0005 : ~dm_rdata;
        if (dm_req[0] === 1'b1 && dm_we[0] === 1'b1) begin
            st_q.push_back({dm_be[3:0], dm_addr[31:0], dm_wdata[31:0]});
        end
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmp(string what, logic [67:0] exp, logic [67:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_fetch(logic [31:0] exp_addr);
        int i;
        for (i = 0; i < 60; i++) begin
            @(posedge core_clk);
            if (pm_req === 1'b1 && pm_valid === 1'b1) break;
        end
        if (i == 60) begin
            n_mismatch++;
            report_and_stop();
        end
        cmp("fetch address", {36'h0, exp_addr}, {36'h0, pm_addr});
    endtask
    // counts a run of back-to-back packets after a fetch
    task automatic collect(output int n, output int f, output logic [7:0] iss);
        n = 0;
        f = 0;
        iss = 8'h00;
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk);
            #1;
            if (pkt_done === 1'b1) begin
                n++;
                f += int'(pkt_fault === 1'b1);
                iss |= unit_issue;
            end else if (n > 0) begin
                break;
            end
        end
    endtask
    task automatic s_nop_padding();
        int n, f;
        logic [7:0] iss;
        wait_fetch(32'h0000_0000);
        collect(n, f, iss);
        cmp("padding packets", 68'd8, 68'(n));
        cmp("padding faults", 68'd0, 68'(f));
    endtask
    task automatic s_wide_packet();
        int n, f;
        logic [7:0] iss;
        wait_fetch(32'h0000_0020);
        collect(n, f, iss);
        cmp("wide packets", 68'd1, 68'(n));
        cmp("wide units", 68'hff, {60'h0, iss});
        cmp("wide stores", 68'd1, 68'(st_q.size()));
        if (st_q.size() == 1) cmp("wide store", {4'hf, 64'h0}, st_q.pop_front());
    endtask
    task automatic s_load_use();
        int n, f;
        logic [7:0] iss;
        @(posedge core_clk);
        slow <= 1'b1;
        wait_fetch(32'h0000_0040);
        collect(n, f, iss);
        cmp("load packets", 68'd8, 68'(n));
        cmp("load stores", 68'd2, 68'(st_q.size()));
        if (st_q.size() != 2) return;
        cmp("word store", {4'hf, 32'h8, 32'ha}, st_q.pop_front());
        cmp("byte store", {4'h8, 32'h3, 32'h0a0a_0a0a}, st_q.pop_front());
    endtask
    task automatic s_fault_hold();
        int n, f;
        logic [7:0] iss;
        logic seen;
        @(posedge core_clk);
        slow <= 1'b0;
        wait_fetch(32'h0000_0060);
        core_run <= 1'b0;
        collect(n, f, iss);
        cmp("fault packets", 68'd7, 68'(n));
        cmp("fault count", 68'd2, 68'(f));
        seen = 1'b0;
        repeat (10) begin
            @(posedge core_clk);
            seen |= pm_req;
        end
        cmp("held fetch", 68'd0, {67'h0, seen});
        core_run <= 1'b1;
        wait_fetch(32'h0000_0080);
        collect(n, f, iss);
        cmp("blank packets", 68'd8, 68'(n));
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        s_nop_padding();
        s_wide_packet();
        s_load_use();
        s_fault_hold();
        report_and_stop();
    end
endmodule
bind vfd_core vfd_core_sva i_vfd_core_sva (.core_clk(core_clk), .sys_rst(sys_rst),
    .core_run(core_run), .pm_req(pm_req), .pm_addr(pm_addr), .pm_valid(pm_valid),
    .dm_req(dm_req), .dm_we(dm_we), .dm_be(dm_be), .unit_issue(unit_issue),
    .pkt_done(pkt_done), .pkt_fault(pkt_fault));
